// *** design/spc_pkg.sv ***
/*
  spc_pkg: constants, register map, field layout and carrier types of the
  spi controller with register file and byte fifos.
  assumes one 25 mhz bus clock that also serves as the spi reference clock.
*/
package spc_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // register byte offsets
  localparam logic [7:0] A_CFG = 8'h00;
  localparam logic [7:0] A_STS = 8'h04;
  localparam logic [7:0] A_IEN = 8'h08;
  localparam logic [7:0] A_IDIS = 8'h0c;
  localparam logic [7:0] A_MASK = 8'h10;
  localparam logic [7:0] A_EN = 8'h14;
  localparam logic [7:0] A_DLY = 8'h18;
  localparam logic [7:0] A_TX = 8'h1c;
  localparam logic [7:0] A_RX = 8'h20;
  localparam logic [7:0] A_IDLE = 8'h24;
  localparam logic [7:0] A_TTHR = 8'h28;
  localparam logic [7:0] A_RTHR = 8'h2c;
  localparam logic [7:0] A_ID = 8'hfc;

  ////////////////////////////////////////////////////////////////////////////
  // event bit positions
  localparam int EV_W = 7;
  localparam int B_TXUF = 6;
  localparam int B_RXFULL = 5;
  localparam int B_RXLVL = 4;
  localparam int B_TXFULL = 3;
  localparam int B_TXLVL = 2;
  localparam int B_MFAULT = 1;
  localparam int B_RXOVR = 0;

  // configuration fields
  localparam int CFG_W = 5;
  localparam int CFG_MASTER = 0;
  localparam int CFG_CPOL = 1;
  localparam int CFG_CPHA = 2;
  localparam int CFG_SEL_LSB = 3;

  // delay fields, lsb of each byte
  localparam int DLY_CSWORD_LSB = 24;
  localparam int DLY_CSCS_LSB = 16;
  localparam int DLY_LASTFIRST_LSB = 8;
  localparam int DLY_SETUP_LSB = 0;

  ////////////////////////////////////////////////////////////////////////////
  // reset values
  localparam logic [EV_W-1:0] IEN_RST = 7'h04;
  localparam logic [EV_W-1:0] STS_RST = 7'h04;
  localparam logic EN_RST = 1'b0;
  localparam logic [31:0] DLY_RST = 32'h0000_0000;
  localparam logic [7:0] IDLE_RST = 8'hff;
  localparam logic [7:0] TTHR_RST = 8'h01;
  localparam logic [7:0] RTHR_RST = 8'h01;
  localparam logic [CFG_W-1:0] CFG_RST = 5'h00;
  // identifier value is arbitrary
  localparam logic [24:0] MODULE_ID = 25'h0a5a5a;

  ////////////////////////////////////////////////////////////////////////////
  // fifo and timing
  localparam int FIFO_DEPTH = 128;
  localparam int FIFO_AW = 7;
  localparam int CLK_PERIOD_NS = 40;
  localparam int SCLK_HALF_NS = 160;
  localparam logic [7:0] SCLK_HALF_CYC = 8'((SCLK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  ////////////////////////////////////////////////////////////////////////////
  // carriers
  typedef struct packed {
    logic sclk;
    logic ss_n;
    logic mosi;
    logic miso;
  } spc_pin_in_type;

  typedef struct packed {
    logic sclk;
    logic mosi;
    logic [2:0] ss_n;
    logic miso;
    logic miso_oe_n;
  } spc_pin_out_type;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_GAP = 3'b001,
    ST_SHIFT = 3'b010,
    ST_CSGAP = 3'b011,
    ST_CHANGE = 3'b100,
    ST_SWAIT = 3'b101,
    ST_SSHIFT = 3'b110
  } spc_state_type;

endpackage : spc_pkg

// *** design/spc_fifo.sv ***
/*
  spc_fifo: byte fifo with count, full and empty flags, first word fall-through.
  assumes push is never given while full by a caller that relies on the data.
*/
`timescale 1ns/1ps
`default_nettype none
module spc_fifo (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic push,
  input wire logic [7:0] din,
  input wire logic pop,
  output logic [7:0] dout,
  output logic [7:0] count,
  output logic full,
  output logic empty
);
  import spc_pkg::*;

  typedef struct packed {
    logic [FIFO_AW-1:0] wp;
    logic [FIFO_AW-1:0] rp;
    logic [7:0] cnt;
  } spc_fifo_state_type;

  logic [7:0] mem [FIFO_DEPTH];
  spc_fifo_state_type r;
  spc_fifo_state_type next_r;
  logic do_push;
  logic do_pop;

  ////////////////////////////////////////////////////////////////////////////
  assign full = (r.cnt == 8'(FIFO_DEPTH));
  assign empty = (r.cnt == 8'h00);
  assign count = r.cnt;
  assign dout = mem[r.rp];
  assign do_push = push && !full;
  assign do_pop = pop && !empty;

  always_comb begin
    next_r = r;
    if (do_push) begin
      next_r.wp = r.wp + 7'h01;
    end
    if (do_pop) begin
      next_r.rp = r.rp + 7'h01;
    end
    next_r.cnt = r.cnt + 8'(do_push) - 8'(do_pop);
  end

  // storage needs no reset; only pointers define contents
  always_ff @(posedge hclk) begin
    if (do_push) begin
      mem[r.wp] <= din;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end
endmodule : spc_fifo
`default_nettype wire

// *** design/spc_top.sv ***
/*
  spc_top: spi controller with ahb-lite register file, 128-byte fifos,
  master and slave byte engines, delays and sticky event flags.
  assumes hclk is the spi reference clock; serial pins arrive asynchronously.
*/
// The AHB-Lite register port was chosen for this implementation.
// Function
// - seven event sources at bits six to zero
// - enable write of one enables source
// - disable write of one disables source
// - mask reads zero enabled, one disabled
// - only transmit level enable resets set
// - enable bit zero gates both byte engines
// - master phase zero: select released between words
// - wait between select release and new select
// - gap between last and first bit
// - wait from select low to first bit
// - transmit write pushes byte, starts transfer
// - both fifos hold 128 bytes
// - receive read pops next byte, low bits
// - slave start needs deselect or idle clock
// - transmit threshold sets transmit level event
// - receive threshold sets receive level event
// - read-only 25-bit module identifier
// - mode fault flags and clears enable
// - status bits sticky, cleared by software write
`timescale 1ns/1ps
`default_nettype none
module spc_top (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire spc_pkg::spc_pin_in_type pin_in,
  output spc_pkg::spc_pin_out_type pin_out,
  output logic irq
);
  import spc_pkg::*;

  typedef struct packed {
    logic [CFG_W-1:0] cfg;
    logic en;
    logic [EV_W-1:0] ien;
    logic [EV_W-1:0] sts;
    logic [31:0] dly;
    logic [7:0] idle;
    logic [7:0] tthr;
    logic [7:0] rthr;
    logic wr_pend;
    logic [7:0] addr;
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
    logic irq;
    spc_pin_in_type sync1;
    spc_pin_in_type sync2;
    logic sclk_prev;
    logic [7:0] quiet;
    logic desel;
    spc_state_type st;
    logic [7:0] cnt;
    logic [7:0] div;
    logic [4:0] half;
    logic [7:0] txsh;
    logic [7:0] rxsh;
    spc_pin_out_type out;
  } spc_top_state_type;

  localparam spc_top_state_type RST_STATE = '{
    cfg: CFG_RST, en: EN_RST, ien: IEN_RST, sts: STS_RST, dly: DLY_RST,
    idle: IDLE_RST, tthr: TTHR_RST, rthr: RTHR_RST, wr_pend: 1'b0,
    addr: 8'h00, hrdata: 32'h0000_0000, hreadyout: 1'b1, hresp: 1'b0,
    // synchronisers start at the idle pin levels, so no false sclk edge follows reset
    irq: 1'b0, sync1: 4'h4, sync2: 4'h4, sclk_prev: 1'b0, quiet: 8'h00,
    desel: 1'b1, st: ST_IDLE, cnt: 8'h00, div: 8'h00, half: 5'h00,
    txsh: 8'h00, rxsh: 8'h00,
    out: '{sclk: 1'b0, mosi: 1'b0, ss_n: 3'b111, miso: 1'b0, miso_oe_n: 1'b1}
  };

  // select field 0..2 picks one active-low line, 3 selects none
  function automatic logic [2:0] cs_decode(input logic [1:0] sel);
    logic [2:0] v;
    v = 3'b111;
    if (sel != 2'b11) begin
      v[sel] = 1'b0;
    end
    return v;
  endfunction : cs_decode

  spc_top_state_type r;
  spc_top_state_type next_r;

  logic tx_push;
  logic tx_pop;
  logic rx_push;
  logic rx_pop;
  logic [7:0] rx_byte;
  logic [7:0] tx_dout;
  logic [7:0] rx_dout;
  logic [7:0] tx_count;
  logic [7:0] rx_count;
  logic tx_full;
  logic tx_empty;
  logic rx_full;
  logic rx_empty;

  ////////////////////////////////////////////////////////////////////////////
  // fifos
  spc_fifo u_tx_fifo (
    .hclk(hclk),
    .hresetn(hresetn),
    .push(tx_push),
    .din(hwdata[7:0]),
    .pop(tx_pop),
    .dout(tx_dout),
    .count(tx_count),
    .full(tx_full),
    .empty(tx_empty)
  );

  spc_fifo u_rx_fifo (
    .hclk(hclk),
    .hresetn(hresetn),
    .push(rx_push),
    .din(rx_byte),
    .pop(rx_pop),
    .dout(rx_dout),
    .count(rx_count),
    .full(rx_full),
    .empty(rx_empty)
  );

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    logic master;
    logic cpha;
    logic sclk_s;
    logic ss_s;
    logic in_bit;
    logic step;
    logic cap;
    logic done;
    logic mfault;
    logic underflow;
    logic addr_ph;
    logic [7:0] nb;
    logic [7:0] word;
    logic [7:0] ld;
    logic [EV_W-1:0] cond;
    next_r = r;
    master = r.cfg[CFG_MASTER];
    cpha = r.cfg[CFG_CPHA];
    sclk_s = r.sync2.sclk;
    ss_s = r.sync2.ss_n;
    in_bit = master ? r.sync2.miso : r.sync2.mosi;
    step = 1'b0;
    cap = 1'b0;
    done = 1'b0;
    mfault = 1'b0;
    underflow = 1'b0;
    nb = {r.rxsh[6:0], in_bit};
    word = 8'h00;
    ld = tx_empty ? 8'h00 : tx_dout;
    tx_push = 1'b0;
    tx_pop = 1'b0;
    rx_push = 1'b0;
    rx_pop = 1'b0;
    rx_byte = 8'h00;
    addr_ph = 1'b0;
    cond = '0;

    // pins pass two flops before any use
    next_r.sync1 = pin_in;
    next_r.sync2 = r.sync1;
    next_r.sclk_prev = sclk_s;

    //////////////////////////////////////////////////////////////////////////
    // bus data phase: writes land here
    if (r.wr_pend) begin
      case (r.addr)
        A_CFG: next_r.cfg = hwdata[CFG_W-1:0];
        A_STS: next_r.sts = r.sts & ~hwdata[EV_W-1:0];
        A_IEN: next_r.ien = r.ien | hwdata[EV_W-1:0];
        A_IDIS: next_r.ien = r.ien & ~hwdata[EV_W-1:0];
        A_EN: next_r.en = hwdata[0];
        A_DLY: next_r.dly = hwdata;
        A_TX: tx_push = 1'b1;
        A_IDLE: next_r.idle = hwdata[7:0];
        A_TTHR: next_r.tthr = hwdata[7:0];
        A_RTHR: next_r.rthr = hwdata[7:0];
        default: ;
      endcase
    end

    //////////////////////////////////////////////////////////////////////////
    // slave-side idle detection
    if (sclk_s != r.sclk_prev) begin
      next_r.quiet = 8'h00;
    end else if (r.quiet != 8'hff) begin
      next_r.quiet = r.quiet + 8'h01;
    end
    if (ss_s) begin
      next_r.desel = 1'b1;
    end

    // multi-master contention
    if (master && r.en && !ss_s) begin
      mfault = 1'b1;
    end

    //////////////////////////////////////////////////////////////////////////
    // shared bit step of master and slave engines
    if (r.st == ST_SHIFT) begin
      if (r.div == SCLK_HALF_CYC - 8'h01) begin
        next_r.div = 8'h00;
        next_r.out.sclk = ~r.out.sclk;
        step = 1'b1;
      end else begin
        next_r.div = r.div + 8'h01;
      end
    end else if (r.st == ST_SSHIFT) begin
      step = (sclk_s != r.sclk_prev);
    end
    if (step) begin
      cap = (r.half[0] == cpha);
      next_r.half = r.half + 5'h01;
      done = (r.half == 5'h0f);
      word = cap ? nb : r.rxsh;
      if (cap) begin
        next_r.rxsh = nb;
      end else begin
        next_r.txsh = {r.txsh[6:0], 1'b0};
        if (master) begin
          next_r.out.mosi = r.txsh[7];
        end else begin
          next_r.out.miso = r.txsh[7];
        end
      end
    end

    //////////////////////////////////////////////////////////////////////////
    case (r.st)
      ST_IDLE: begin
        next_r.out.sclk = r.cfg[CFG_CPOL];
        next_r.out.ss_n = 3'b111;
        if (r.en && master && !tx_empty) begin
          tx_pop = 1'b1;
          next_r.txsh = tx_dout;
          next_r.out.ss_n = cs_decode(r.cfg[CFG_SEL_LSB +: 2]);
          next_r.cnt = r.dly[DLY_SETUP_LSB +: 8];
          next_r.st = ST_GAP;
        end else if (r.en && !master) begin
          next_r.st = ST_SWAIT;
        end
      end
      ST_GAP: begin
        if (r.cnt == 8'h00) begin
          next_r.st = ST_SHIFT;
          next_r.half = 5'h00;
          next_r.div = 8'h00;
          if (!cpha) begin
            next_r.out.mosi = r.txsh[7];
            next_r.txsh = {r.txsh[6:0], 1'b0};
          end
        end else begin
          next_r.cnt = r.cnt - 8'h01;
        end
      end
      ST_SHIFT: begin
        if (done) begin
          rx_push = 1'b1;
          rx_byte = word;
          if (!tx_empty) begin
            tx_pop = 1'b1;
            next_r.txsh = tx_dout;
            if (!cpha) begin
              next_r.out.ss_n = 3'b111;
              next_r.cnt = r.dly[DLY_CSWORD_LSB +: 8];
              next_r.st = ST_CSGAP;
            end else begin
              next_r.cnt = r.dly[DLY_LASTFIRST_LSB +: 8];
              next_r.st = ST_GAP;
            end
          end else begin
            next_r.out.ss_n = 3'b111;
            next_r.cnt = r.dly[DLY_CSCS_LSB +: 8];
            next_r.st = ST_CHANGE;
          end
        end
      end
      ST_CSGAP: begin
        if (r.cnt == 8'h00) begin
          next_r.out.ss_n = cs_decode(r.cfg[CFG_SEL_LSB +: 2]);
          next_r.cnt = r.dly[DLY_LASTFIRST_LSB +: 8];
          next_r.st = ST_GAP;
        end else begin
          next_r.cnt = r.cnt - 8'h01;
        end
      end
      ST_CHANGE: begin
        if (r.cnt == 8'h00) begin
          next_r.st = ST_IDLE;
        end else begin
          next_r.cnt = r.cnt - 8'h01;
        end
      end
      ST_SWAIT: begin
        next_r.out.miso_oe_n = 1'b1;
        if (master || !r.en) begin
          next_r.st = ST_IDLE;
        end else if (!ss_s && (r.desel || r.quiet >= r.idle)) begin
          next_r.desel = 1'b0;
          tx_pop = !tx_empty;
          underflow = tx_empty;
          next_r.half = 5'h00;
          next_r.out.miso_oe_n = 1'b0;
          next_r.txsh = ld;
          next_r.st = ST_SSHIFT;
          if (!cpha) begin
            next_r.out.miso = ld[7];
            next_r.txsh = {ld[6:0], 1'b0};
          end
        end
      end
      ST_SSHIFT: begin
        if (ss_s) begin
          mfault = 1'b1;
          next_r.out.miso_oe_n = 1'b1;
          next_r.st = ST_SWAIT;
        end else if (done) begin
          rx_push = 1'b1;
          rx_byte = word;
          next_r.out.miso_oe_n = 1'b1;
          next_r.st = ST_SWAIT;
        end
      end
      default: next_r.st = ST_IDLE;
    endcase

    // a fault outranks any software write of the enable
    if (mfault) begin
      next_r.en = 1'b0;
    end
    // dropping the enable aborts any word in flight
    if (!next_r.en && r.st != ST_IDLE) begin
      next_r.st = ST_IDLE;
      next_r.out.ss_n = 3'b111;
      next_r.out.miso_oe_n = 1'b1;
    end

    //////////////////////////////////////////////////////////////////////////
    // sticky events, set wins over a clear in the same cycle
    cond[B_TXUF] = underflow;
    cond[B_RXFULL] = rx_full;
    cond[B_RXLVL] = (rx_count >= r.rthr);
    cond[B_TXFULL] = tx_full;
    cond[B_TXLVL] = (tx_count < r.tthr);
    cond[B_MFAULT] = mfault;
    cond[B_RXOVR] = rx_push && rx_full;
    next_r.sts = next_r.sts | cond;

    //////////////////////////////////////////////////////////////////////////
    // bus address phase: read data registered for the data phase
    addr_ph = hsel && hready && htrans[1];
    next_r.wr_pend = addr_ph && hwrite;
    if (addr_ph) begin
      next_r.addr = haddr[7:0];
    end
    if (addr_ph && !hwrite) begin
      case (haddr[7:0])
        A_CFG: next_r.hrdata = {27'h0, next_r.cfg};
        A_STS: next_r.hrdata = {25'h0, next_r.sts};
        A_MASK: next_r.hrdata = {25'h0, ~next_r.ien};
        A_EN: next_r.hrdata = {31'h0, next_r.en};
        A_DLY: next_r.hrdata = next_r.dly;
        A_RX: begin
          next_r.hrdata = {24'h0, rx_dout};
          rx_pop = 1'b1;
        end
        A_IDLE: next_r.hrdata = {24'h0, next_r.idle};
        A_TTHR: next_r.hrdata = {24'h0, next_r.tthr};
        A_RTHR: next_r.hrdata = {24'h0, next_r.rthr};
        A_ID: next_r.hrdata = {7'h0, MODULE_ID};
        default: next_r.hrdata = 32'h0000_0000;
      endcase
    end
    next_r.hreadyout = 1'b1;
    next_r.hresp = 1'b0;
    next_r.irq = |(next_r.sts & next_r.ien);
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      r <= RST_STATE;
    end else begin
      r <= next_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  assign hrdata = r.hrdata;
  assign hreadyout = r.hreadyout;
  assign hresp = r.hresp;
  assign pin_out = r.out;
  assign irq = r.irq;

endmodule : spc_top
`default_nettype wire

// *** verif/spc_checker.sv ***
/*
  spc_checker: bus, mask and select timing assertions on spc_top.
  assumes cpol 0 on the link; bound to spc_top at the foot.
*/
`timescale 1ns/1ps
`default_nettype none
module spc_checker (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire spc_pkg::spc_pin_in_type pin_in,
  input wire spc_pkg::spc_pin_out_type pin_out,
  input wire logic irq
);
  import spc_pkg::*;
  logic aw;
  logic [7:0] aa;
  logic [6:0] ien;
  logic [31:0] dly;
  logic [8:0] hi;
  logic [8:0] su;
  wire logic rd = hsel && hready && htrans[1] && !hwrite;
  // later words may use the word gap instead of the setup wait
  wire logic [7:0] m_su = (dly[7:0] < dly[15:8]) ? dly[7:0] : dly[15:8];
  wire logic [7:0] m_hi = (dly[31:24] < dly[23:16]) ? dly[31:24] : dly[23:16];
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  ////////////////////////////////////////////////////////////////////////////
  // shadows of bus writes and select counters
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      aw <= 1'b0;
      aa <= 8'h00;
      ien <= IEN_RST;
      dly <= DLY_RST;
      hi <= 9'h1ff;
      su <= 9'h000;
    end else begin
      aw <= hsel && hready && htrans[1] && hwrite;
      aa <= haddr[7:0];
      if (aw && aa == A_IEN) ien <= ien | hwdata[6:0];
      if (aw && aa == A_IDIS) ien <= ien & ~hwdata[6:0];
      if (aw && aa == A_DLY) dly <= hwdata;
      hi <= !(&pin_out.ss_n) ? 9'h000 : hi + 9'(hi != 9'h1ff);
      su <= (&pin_out.ss_n) ? 9'h000 : su + 9'(su != 9'h1ff);
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  bus_okay_a: assert property (hreadyout && !hresp)
    else $error("slave not ready or not okay");
  irq_reset_a: assert property ($rose(hresetn) |-> ##[1:2] irq)
    else $error("no irq after reset");
  id_read_a: assert property (rd && haddr[7:0] == A_ID |=> hrdata == {7'h0, MODULE_ID})
    else $error("identifier read wrong");
  hole_read_a: assert property (rd && haddr[7:0] >= 8'h30 && haddr[7:0] < A_ID |=> hrdata == 32'h0)
    else $error("unmapped read not zero");
  mask_read_a: assert property (rd && haddr[7:0] == A_MASK |=> hrdata == {25'h0, ~ien})
    else $error("mask read wrong");
  one_select_a: assert property ($countones(~pin_out.ss_n) <= 1)
    else $error("two selects low");
  idle_clock_a: assert property (&pin_out.ss_n |-> !pin_out.sclk)
    else $error("clock not idle when deselected");
  select_setup_a: assert property ($changed(pin_out.sclk) && !(&pin_out.ss_n) |-> su >= m_su)
    else $error("clock too soon after select");
  deselect_gap_a: assert property ($fell(&pin_out.ss_n) |-> hi >= m_hi)
    else $error("deselect gap too short");
endmodule : spc_checker

bind spc_top spc_checker u_spc_checker (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
  .hreadyout(hreadyout), .hresp(hresp), .pin_in(pin_in), .pin_out(pin_out), .irq(irq));
`default_nettype wire

// *** verif/spc_slave_model.sv ***
/*
  spc_slave_model: serial slave on select 0, mode 0, msb first.
  assumes sclk idles low; no pull on miso, so it flips when released.
*/
`timescale 1ns/1ps
`default_nettype none
module spc_slave_model (
  input wire logic sclk,
  input wire logic ss_n,
  input wire logic mosi,
  output logic miso,
  output int nbytes,
  output logic [7:0] got [0:255]
);
  logic [7:0] tx;
  logic [7:0] rx;
  int nbit;
  initial begin
    miso = 1'b0;
    nbytes = 0;
    nbit = 0;
  end
  ////////////////////////////////////////////////////////////////////////////
  // reply byte depends only on the word count, so the bench can predict it
  always @(negedge ss_n) begin
    tx = 8'(nbytes * 37 + 5);
    nbit = 0;
    miso = tx[7];
  end
  always @(posedge ss_n) miso = ~miso;
  always @(posedge sclk) if (!ss_n) begin
    rx = {rx[6:0], mosi};
    nbit++;
    if (nbit == 8) begin
      got[nbytes] = rx;
      nbytes++;
    end
  end
  always @(negedge sclk) if (!ss_n) begin
    tx = {tx[6:0], 1'b0};
    miso = tx[7];
  end
endmodule : spc_slave_model
`default_nettype wire

// *** verif/spc_top_tb.sv ***
/*
  spc_top_tb: random and corner tests of spc_top over ahb-lite.
  assumes spc_slave_model on select 0, mode 0; the bench plays master for one slave byte.
*/
`timescale 1ns/1ps
`default_nettype none
module spc_top_tb;
  import spc_pkg::*;
  logic hclk, hresetn, hsel, hwrite, ss_in_n, miso_w, irq, hreadyout, hresp, sclk_in, mosi_in;
  logic [31:0] haddr, hwdata, hrdata, w, r;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [6:0] en;
  logic [7:0] txq [0:127];
  logic [7:0] got [0:255];
  logic [7:0] ra [4];
  logic [31:0] rm [4];
  spc_pin_in_type pin_in;
  spc_pin_out_type pin_out;
  int num_errors, n_tests, nb;
  assign pin_in = {sclk_in, ss_in_n, mosi_in, miso_w};
  spc_top u_spc_top (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .pin_in(pin_in), .pin_out(pin_out), .irq(irq));
  spc_slave_model u_spc_slave_model (.sclk(pin_out.sclk), .ss_n(pin_out.ss_n[0]),
    .mosi(pin_out.mosi), .miso(miso_w), .nbytes(nb), .got(got));
  always #20 hclk = ~hclk;
  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [7:0] rx_exp(input int k);
    return 8'(k * 37 + 5);
  endfunction : rx_exp
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    n_tests++;
    if (s !== e) begin
      num_errors++;
      $display("unexpected at %0t: got %h want %h", $time, s, e);
    end
  endtask : chk
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= wr;
    haddr <= {24'h0, a};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask : bus
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(r, e);
  endtask : rdc
  // waits for the last word to finish; select rises on the same edge as the rx push
  task automatic drain(input int n);
    for (int c = 0; c < 40000 && !(nb == n && &pin_out.ss_n); c++) @(posedge hclk);
    chk(32'(nb), 32'(n));
    repeat (4) @(posedge hclk);
  endtask : drain
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : summarize
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (60000) @(posedge hclk);
    num_errors++;
    summarize();
  end
  initial begin
    hclk = 1'b0;
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'b010;
    hwdata = 32'h0;
    ss_in_n = 1'b1;
    sclk_in = 1'b0;
    mosi_in = 1'b0;
    ra = '{A_DLY, A_IDLE, A_TTHR, A_RTHR};
    rm = '{32'hffffffff, 32'hff, 32'hff, 32'hff};
    w = $urandom(32'h47c1);
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rdc(A_MASK, {25'h0, ~IEN_RST});
    rdc(A_EN, 32'h0);
    rdc(A_DLY, 32'h0);
    rdc(A_IDLE, 32'hff);
    rdc(A_TTHR, 32'h1);
    rdc(A_RTHR, 32'h1);
    rdc(A_ID, {7'h0, MODULE_ID});
    rdc(A_STS, 32'h4);
    chk({31'h0, irq}, 32'h1);
    en = IEN_RST;
    repeat (8) begin
      w = $urandom;
      en = en | w[6:0];
      bus(1'b1, A_IEN, w);
      rdc(A_MASK, {25'h0, ~en});
      w = $urandom;
      en = en & ~w[6:0];
      bus(1'b1, A_IDIS, w);
      rdc(A_MASK, {25'h0, ~en});
    end
    bus(1'b1, A_IDIS, 32'h7f);
    rdc(A_MASK, 32'h7f);
    chk({31'h0, irq}, 32'h0);
    bus(1'b1, A_IEN, 32'h4);
    rdc(A_MASK, 32'h7b);
    chk({31'h0, irq}, 32'h1);
    for (int i = 0; i < 4; i++) begin
      w = $urandom;
      bus(1'b1, ra[i], w);
      rdc(ra[i], w & rm[i]);
    end
    bus(1'b1, 8'h40, 32'hffffffff);
    rdc(8'h40, 32'h0);
    bus(1'b1, A_ID, 32'h0);
    rdc(A_ID, {7'h0, MODULE_ID});
    // small delays keep the 128-word burst short
    bus(1'b1, A_DLY, $urandom & 32'h0f0f0f0f);
    bus(1'b1, A_TTHR, 32'h1);
    bus(1'b1, A_RTHR, 32'h1);
    bus(1'b1, 8'h00, 32'h1);
    for (int k = 0; k < 128; k++) begin
      if (k == 127) begin
        bus(1'b1, A_STS, 32'hffffffff);
        rdc(A_STS, 32'h0);
      end
      w = $urandom;
      txq[k] = w[7:0];
      bus(1'b1, A_TX, w);
    end
    rdc(A_STS, 32'h8);
    bus(1'b1, A_EN, 32'h1);
    drain(128);
    rdc(A_STS, 32'h3c);
    for (int k = 0; k < 128; k++) begin
      rdc(A_RX, {24'h0, rx_exp(k)});
      chk({24'h0, got[k]}, {24'h0, txq[k]});
    end
    w = $urandom;
    bus(1'b1, A_TX, w);
    drain(129);
    rdc(A_RX, {24'h0, rx_exp(128)});
    chk({24'h0, got[128]}, {24'h0, w[7:0]});
    ss_in_n <= 1'b0;
    repeat (8) @(posedge hclk);
    ss_in_n <= 1'b1;
    rdc(A_EN, 32'h0);
    bus(1'b0, A_STS, 32'h0);
    chk({31'h0, r[1]}, 32'h1);
    bus(1'b1, A_STS, 32'h2);
    bus(1'b0, A_STS, 32'h0);
    chk({31'h0, r[1]}, 32'h0);
    // slave mode, phase 0: the bench drives sclk at 320 ns and checks miso before each rise
    w = $urandom;
    bus(1'b1, A_CFG, 32'h0);
    bus(1'b1, A_TX, w);
    bus(1'b1, A_EN, 32'h1);
    ss_in_n <= 1'b0;
    repeat (4) @(posedge hclk);
    for (int i = 7; i >= 0; i--) begin
      mosi_in <= ~w[i];
      repeat (4) @(posedge hclk);
      chk({30'h0, pin_out.miso, pin_out.miso_oe_n}, {30'h0, w[i], 1'b0});
      sclk_in <= 1'b1;
      repeat (4) @(posedge hclk);
      sclk_in <= 1'b0;
    end
    repeat (4) @(posedge hclk);
    ss_in_n <= 1'b1;
    rdc(A_RX, {24'h0, ~w[7:0]});
    summarize();
  end
endmodule : spc_top_tb
`default_nettype wire
